// ==== rtl/smer_pkg.sv ====
// Package for the event routing register group of the serial master.
// Assumes a 32-bit register port with byte offsets.
package smer_pkg;
    localparam logic [11:0] OFS_PUB_RX_FULL = 12'h190;
    localparam logic [11:0] OFS_PUB_BOTH_DONE = 12'h198;
    localparam logic [11:0] OFS_PUB_TX_DONE = 12'h1a0;
    localparam logic [11:0] OFS_PUB_BEGUN = 12'h1cc;
    localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_EV_HALTED = 12'h104;
    localparam logic [11:0] OFS_EV_RX_FULL = 12'h110;
    localparam logic [11:0] OFS_EV_BOTH_DONE = 12'h118;
    localparam logic [11:0] OFS_EV_TX_DONE = 12'h120;
    localparam logic [11:0] OFS_EV_BEGUN = 12'h14c;
    localparam int PUBLISH_CHANNEL_INDEX_LSB = 0;
    localparam int PUBLISH_CHANNEL_INDEX_W = 16;
    localparam int PUB_EN_BIT = 31;
    localparam int SHORT_END_START_BIT = 0;
    // Event bit positions in the internal event and enable vectors
    localparam int EV_HALTED = 0;
    localparam int EV_RX_FULL = 1;
    localparam int EV_BOTH_DONE = 2;
    localparam int EV_TX_DONE = 3;
    localparam int EV_BEGUN = 4;
    localparam int EV_N = 5;
    localparam int IRQ_POS_HALTED = 1;
    localparam int IRQ_POS_RX_FULL = 4;
    localparam int IRQ_POS_BOTH_DONE = 6;
    localparam int IRQ_POS_TX_DONE = 8;
    localparam int IRQ_POS_BEGUN = 19;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : smer_pkg

// ==== rtl/smer_pub_if.sv ====
// Interface carrying one publish configuration between modules.
// Assumes the owner and the user share i_clk.
`timescale 1ns/10ps
`default_nettype none
interface smer_pub_if;
    logic [31:0] wdata;
    logic wr;
    logic [31:0] cfg;
    logic event_in;
    logic enabled;
    logic [15:0] channel;
    logic fire;
    modport owner(input wdata, input wr, input event_in, output cfg,
                  output enabled, output channel, output fire);
    modport user(output wdata, output wr, output event_in, input cfg,
                 input enabled, input channel, input fire);
endinterface : smer_pub_if
`default_nettype wire

// ==== rtl/smer_pub_reg.sv ====
// One publish configuration register and its event forwarding.
// Assumes event pulses are synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module smer_pub_reg
    import smer_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Register side
    smer_pub_if.owner p
);
    logic [31:0] cfg_r;
    logic fire_r;

    // Only channel index and enable bits are stored, the rest read zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_r <= RST_WORD;
        end else if (i_ce && p.wr) begin
            cfg_r <= p.wdata & {1'b1, 15'h0000, 16'hffff};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fire_r <= 1'b0;
        end else if (i_ce) begin
            fire_r <= p.event_in & cfg_r[PUB_EN_BIT];
        end
    end

    assign p.cfg = cfg_r;
    assign p.enabled = cfg_r[PUB_EN_BIT];
    assign p.channel = cfg_r[PUBLISH_CHANNEL_INDEX_LSB +: PUBLISH_CHANNEL_INDEX_W];
    assign p.fire = fire_r;
endmodule : smer_pub_reg
`default_nettype wire

// ==== rtl/smer_top.sv ====
// Event routing registers of the serial master: publish, shortcut, irq.
// Assumes event inputs are one-cycle pulses from logic on i_clk.
`timescale 1ns/10ps
`default_nettype none
module smer_top
    import smer_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Event pulses from the transfer logic
    input wire logic i_ev_halted,
    input wire logic i_ev_rx_full,
    input wire logic i_ev_both_done,
    input wire logic i_ev_tx_done,
    input wire logic i_ev_begun,
    // Interconnect publish outputs
    output logic o_pub_rx_full,
    output logic [15:0] o_pub_rx_full_ch,
    output logic o_pub_both_done,
    output logic [15:0] o_pub_both_done_ch,
    output logic o_pub_tx_done,
    output logic [15:0] o_pub_tx_done_ch,
    output logic o_pub_begun,
    output logic [15:0] o_pub_begun_ch,
    // Shortcut task and interrupt
    output logic o_start_task,
    output logic o_irq
);
    smer_pub_if pif [4] ();
    logic [EV_N-1:0] ev_in;
    logic [EV_N-1:0] ev_r;
    logic [EV_N-1:0] ev_nxt;
    logic [EV_N-1:0] ev_wr;
    logic [EV_N-1:0] ien_r;
    logic [EV_N-1:0] ien_nxt;
    logic [EV_N-1:0] set_bits;
    logic [EV_N-1:0] clr_bits;
    logic short_r;
    logic start_r;
    logic irq_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;
    logic [31:0] ien_word;
    logic [11:0] pub_ofs [4];

    assign ev_in = {i_ev_begun, i_ev_tx_done, i_ev_both_done,
                    i_ev_rx_full, i_ev_halted};
    assign pub_ofs[0] = OFS_PUB_RX_FULL;
    assign pub_ofs[1] = OFS_PUB_BOTH_DONE;
    assign pub_ofs[2] = OFS_PUB_TX_DONE;
    assign pub_ofs[3] = OFS_PUB_BEGUN;

    // Four identical publish registers, index order rx, both, tx, begun
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pub
            assign pif[g].wdata = i_wdata;
            assign pif[g].wr = i_wr && (i_addr == pub_ofs[g]);
            smer_pub_reg u_pub (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_ce(i_ce),
                .p(pif[g])
            );
        end
    endgenerate

    assign pif[0].event_in = i_ev_rx_full;
    assign pif[1].event_in = i_ev_both_done;
    assign pif[2].event_in = i_ev_tx_done;
    assign pif[3].event_in = i_ev_begun;

    assign o_pub_rx_full = pif[0].fire;
    assign o_pub_rx_full_ch = pif[0].channel;
    assign o_pub_both_done = pif[1].fire;
    assign o_pub_both_done_ch = pif[1].channel;
    assign o_pub_tx_done = pif[2].fire;
    assign o_pub_tx_done_ch = pif[2].channel;
    assign o_pub_begun = pif[3].fire;
    assign o_pub_begun_ch = pif[3].channel;

    // Shortcut register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            short_r <= 1'b0;
        end else if (i_ce && i_wr && i_addr == OFS_EVENT_TASK_SHORTCUTS) begin
            short_r <= i_wdata[SHORT_END_START_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            start_r <= 1'b0;
        end else if (i_ce) begin
            start_r <= i_ev_both_done & short_r;
        end
    end
    assign o_start_task = start_r;

    // Enable bits live at scattered positions of the set and clear words
    always_comb begin
        set_bits = '0;
        clr_bits = '0;
        if (i_wr && i_addr == OFS_IRQ_SET) begin
            set_bits[EV_HALTED] = i_wdata[IRQ_POS_HALTED];
            set_bits[EV_RX_FULL] = i_wdata[IRQ_POS_RX_FULL];
            set_bits[EV_BOTH_DONE] = i_wdata[IRQ_POS_BOTH_DONE];
            set_bits[EV_TX_DONE] = i_wdata[IRQ_POS_TX_DONE];
            set_bits[EV_BEGUN] = i_wdata[IRQ_POS_BEGUN];
        end
        if (i_wr && i_addr == OFS_IRQ_CLR) begin
            clr_bits[EV_HALTED] = i_wdata[IRQ_POS_HALTED];
            clr_bits[EV_RX_FULL] = i_wdata[IRQ_POS_RX_FULL];
            clr_bits[EV_BOTH_DONE] = i_wdata[IRQ_POS_BOTH_DONE];
            clr_bits[EV_TX_DONE] = i_wdata[IRQ_POS_TX_DONE];
            clr_bits[EV_BEGUN] = i_wdata[IRQ_POS_BEGUN];
        end
        // Zeros written to either word leave the state alone
        ien_nxt = (ien_r | set_bits) & ~clr_bits;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ien_r <= '0;
        end else if (i_ce) begin
            ien_r <= ien_nxt;
        end
    end

    // Event registers: hardware set wins over a software write of zero
    always_comb begin
        ev_wr[EV_HALTED] = i_wr && i_addr == OFS_EV_HALTED;
        ev_wr[EV_RX_FULL] = i_wr && i_addr == OFS_EV_RX_FULL;
        ev_wr[EV_BOTH_DONE] = i_wr && i_addr == OFS_EV_BOTH_DONE;
        ev_wr[EV_TX_DONE] = i_wr && i_addr == OFS_EV_TX_DONE;
        ev_wr[EV_BEGUN] = i_wr && i_addr == OFS_EV_BEGUN;
        for (int k = 0; k < EV_N; k++) begin
            ev_nxt[k] = ev_in[k] | (ev_wr[k] ? i_wdata[0] : ev_r[k]);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ev_r <= '0;
        end else if (i_ce) begin
            ev_r <= ev_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_r <= 1'b0;
        end else if (i_ce) begin
            irq_r <= |(ev_nxt & ien_nxt);
        end
    end
    assign o_irq = irq_r;

    always_comb begin
        ien_word = '0;
        ien_word[IRQ_POS_HALTED] = ien_r[EV_HALTED];
        ien_word[IRQ_POS_RX_FULL] = ien_r[EV_RX_FULL];
        ien_word[IRQ_POS_BOTH_DONE] = ien_r[EV_BOTH_DONE];
        ien_word[IRQ_POS_TX_DONE] = ien_r[EV_TX_DONE];
        ien_word[IRQ_POS_BEGUN] = ien_r[EV_BEGUN];
    end

    // Unmapped addresses read zero
    always_comb begin
        unique case (i_addr)
            OFS_PUB_RX_FULL: rd_mux = pif[0].cfg;
            OFS_PUB_BOTH_DONE: rd_mux = pif[1].cfg;
            OFS_PUB_TX_DONE: rd_mux = pif[2].cfg;
            OFS_PUB_BEGUN: rd_mux = pif[3].cfg;
            OFS_EVENT_TASK_SHORTCUTS: rd_mux = {31'h0000_0000, short_r};
            OFS_IRQ_SET: rd_mux = ien_word;
            OFS_IRQ_CLR: rd_mux = ien_word;
            OFS_EV_HALTED: rd_mux = {31'h0000_0000, ev_r[EV_HALTED]};
            OFS_EV_RX_FULL: rd_mux = {31'h0000_0000, ev_r[EV_RX_FULL]};
            OFS_EV_BOTH_DONE: rd_mux = {31'h0000_0000, ev_r[EV_BOTH_DONE]};
            OFS_EV_TX_DONE: rd_mux = {31'h0000_0000, ev_r[EV_TX_DONE]};
            OFS_EV_BEGUN: rd_mux = {31'h0000_0000, ev_r[EV_BEGUN]};
            default: rd_mux = RST_WORD;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_r <= RST_WORD;
        end else if (i_ce) begin
            rdata_r <= i_rd ? rd_mux : RST_WORD;
        end
    end
    assign o_rdata = rdata_r;
endmodule : smer_top
`default_nettype wire

// ==== tb/smer_far_end.sv ====
// Model of the transfer logic that raises event pulses.
// Assumes requests change just after a rising edge of i_clk.
`timescale 1ns/10ps
`default_nettype none
module smer_far_end
    import smer_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Requests in, one-cycle pulses out, idle low
    input wire logic [EV_N-1:0] i_req,
    output logic [EV_N-1:0] o_ev
);
    // Registered so a pulse never straddles an edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ev <= '0;
        end else begin
            o_ev <= i_req;
        end
    end
endmodule : smer_far_end
`default_nettype wire

// ==== tb/smer_monitor.sv ====
// Checker for the event routing registers of the serial master.
// Assumes it is bound to smer_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module smer_monitor
    import smer_pkg::*;
(
    // Clock, reset, register port
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Events and outputs
    input wire logic i_ev_rx_full,
    input wire logic i_ev_both_done,
    input wire logic i_ev_tx_done,
    input wire logic i_ev_begun,
    input wire logic o_pub_rx_full,
    input wire logic o_pub_both_done,
    input wire logic o_pub_tx_done,
    input wire logic [15:0] o_pub_tx_done_ch,
    input wire logic o_pub_begun,
    input wire logic o_start_task,
    input wire logic o_irq
);
    // Clock enable low freezes the block, so checking pauses with it
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n || !i_ce);
    sequence s_rx_on;
        i_wr && i_addr == OFS_PUB_RX_FULL && i_wdata[PUB_EN_BIT];
    endsequence
    sequence s_clr_all;
        i_wr && i_addr == OFS_IRQ_CLR && &i_wdata;
    endsequence
    property p_rx_fwd;
        s_rx_on ##1 !i_wr ##1 (i_ev_rx_full && !i_wr) |=> o_pub_rx_full;
    endproperty
    property p_rx_src; o_pub_rx_full |-> $past(i_ev_rx_full); endproperty
    property p_tx_src; o_pub_tx_done |-> $past(i_ev_tx_done); endproperty
    property p_bg_src; o_pub_begun |-> $past(i_ev_begun); endproperty
    property p_bd_src; o_pub_both_done |-> $past(i_ev_both_done); endproperty
    property p_start; o_start_task |-> $past(i_ev_both_done); endproperty
    property p_tx_ch;
        i_wr && i_addr == OFS_PUB_TX_DONE
            |=> {16'h0, o_pub_tx_done_ch} == ($past(i_wdata) & 32'hffff);
    endproperty
    property p_clr; s_clr_all |=> !o_irq; endproperty
    property p_rd_clr;
        s_clr_all ##1 (i_rd && i_addr == OFS_IRQ_SET) |=> o_rdata == 32'h0;
    endproperty
    a_rx_fwd: assert property(p_rx_fwd) else $error("rx pub lost");
    a_rx_src: assert property(p_rx_src) else $error("rx pub odd");
    a_tx_src: assert property(p_tx_src) else $error("tx pub odd");
    a_bg_src: assert property(p_bg_src) else $error("bg pub odd");
    a_bd_src: assert property(p_bd_src) else $error("bd pub odd");
    a_start: assert property(p_start) else $error("start odd");
    a_tx_ch: assert property(p_tx_ch) else $error("tx chan");
    a_clr: assert property(p_clr) else $error("irq stays");
    a_rd_clr: assert property(p_rd_clr) else $error("enables");
endmodule : smer_monitor
bind smer_top smer_monitor u_mon(.i_clk, .i_arst_n, .i_ce, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ev_rx_full, .i_ev_both_done,
    .i_ev_tx_done, .i_ev_begun, .o_pub_rx_full, .o_pub_both_done,
    .o_pub_tx_done, .o_pub_tx_done_ch, .o_pub_begun, .o_start_task, .o_irq);
`default_nettype wire

// ==== tb/smer_tb.sv ====
// Bench for the event routing registers of the serial master.
// Assumes smer_top, its checker and the event source model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
    import smer_pkg::*;
();
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_ce = 1'b1;
    logic [11:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [EV_N-1:0] req = '0;
    logic [31:0] v;
    wire logic [EV_N-1:0] ev;
    wire logic [31:0] o_rdata;
    wire logic [3:0] pub;
    wire logic [15:0] ch [4];
    wire logic start;
    wire logic irq;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    smer_top DUT(.i_clk, .i_arst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_ev_halted(ev[0]), .i_ev_rx_full(ev[1]),
        .i_ev_both_done(ev[2]), .i_ev_tx_done(ev[3]), .i_ev_begun(ev[4]),
        .o_pub_rx_full(pub[0]), .o_pub_rx_full_ch(ch[0]),
        .o_pub_both_done(pub[1]), .o_pub_both_done_ch(ch[1]),
        .o_pub_tx_done(pub[2]), .o_pub_tx_done_ch(ch[2]),
        .o_pub_begun(pub[3]), .o_pub_begun_ch(ch[3]),
        .o_start_task(start), .o_irq(irq));
    smer_far_end far(.i_clk, .i_arst_n, .i_req(req), .o_ev(ev));
    initial forever #25 i_clk = ~i_clk;
    // Tasks are entered and left in the time step of a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        // Strobe stays up so back-to-back writes keep it high with no gap;
        // whichever task follows lowers it at the same edge
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        i_wr <= 1'b0;
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
        @(posedge i_clk);
    endtask : rd
    task automatic fire(input int k, output logic [5:0] s);
        i_wr <= 1'b0;
        req <= 5'(1 << k);
        @(posedge i_clk);
        req <= '0;
        @(posedge i_clk);
        @(negedge i_clk);
        s = {irq, start, pub};
        @(posedge i_clk);
    endtask : fire
    task automatic t_reset();
        logic [11:0] ofs [5] = '{OFS_PUB_RX_FULL, OFS_PUB_TX_DONE,
            OFS_PUB_BEGUN, OFS_EVENT_TASK_SHORTCUTS, OFS_IRQ_SET};
        foreach (ofs[i]) begin
            rd(ofs[i], v);
            `CHK(v, 32'h0)
        end
        wr(12'h7fc, 32'hffff_ffff);
        rd(12'h7fc, v);
        `CHK(v, 32'h0)
    endtask : t_reset
    task automatic t_pub();
        logic [11:0] ofs [4] = '{OFS_PUB_RX_FULL, OFS_PUB_BOTH_DONE,
            OFS_PUB_TX_DONE, OFS_PUB_BEGUN};
        logic [15:0] c;
        logic [5:0] s;
        for (int k = 0; k < 4; k++) begin
            c = k[0] ? 16'hffff : 16'h0001 + 16'(k);
            wr(ofs[k], {1'b1, 15'h7fff, c});
            fire(k + 1, s);
            `CHK(s, 6'(1 << k))
            `CHK(ch[k], c)
            rd(ofs[k], v);
            `CHK(v, {1'b1, 15'h0, c})
            wr(ofs[k], {16'h0, c});
            fire(k + 1, s);
            `CHK(s, 6'h0)
        end
    endtask : t_pub
    task automatic t_short();
        logic [5:0] s;
        // A write while the clock enable is low must not land
        i_ce <= 1'b0;
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h1);
        i_ce <= 1'b1;
        rd(OFS_EVENT_TASK_SHORTCUTS, v);
        `CHK(v, 32'h0)
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h1);
        fire(EV_BOTH_DONE, s);
        `CHK(s[4], 1'b1)
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h0);
        fire(EV_BOTH_DONE, s);
        `CHK(s[4], 1'b0)
    endtask : t_short
    task automatic t_irq();
        int pos [5] = '{IRQ_POS_HALTED, IRQ_POS_RX_FULL, IRQ_POS_BOTH_DONE,
            IRQ_POS_TX_DONE, IRQ_POS_BEGUN};
        logic [11:0] eo [5] = '{OFS_EV_HALTED, OFS_EV_RX_FULL,
            OFS_EV_BOTH_DONE, OFS_EV_TX_DONE, OFS_EV_BEGUN};
        logic [5:0] s;
        for (int k = 0; k < EV_N; k++) begin
            wr(eo[k], 32'h0);
            wr(OFS_IRQ_SET, 32'h1 << pos[k]);
            wr(OFS_IRQ_SET, 32'h0);
            rd(OFS_IRQ_SET, v);
            `CHK(v, 32'h1 << pos[k])
            fire(k, s);
            `CHK(s[5], 1'b1)
            rd(eo[k], v);
            `CHK(v, 32'h1)
            wr(OFS_IRQ_CLR, 32'h1 << pos[k]);
            rd(OFS_IRQ_CLR, v);
            `CHK(v, 32'h0)
        end
        wr(OFS_IRQ_SET, 32'hffff_ffff);
        wr(OFS_IRQ_CLR, 32'hffff_ffff);
        rd(OFS_IRQ_SET, v);
        `CHK(v, 32'h0)
        fire(EV_HALTED, s);
        `CHK(s[5], 1'b0)
    endtask : t_irq
    task automatic finish_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // Whole run is about 150 cycles; the ceiling only catches a hang
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_pub();
        t_short();
        t_irq();
        finish_test();
    end
endmodule : tb
`default_nettype wire
